// ### testbench/cbtoc_xcvr.sv
/* Bus transceiver model facing the two driver lines.
   Assumes active-high gate outputs and 0 for dominant at the comparator. */
`timescale 1ns/10ps
`default_nettype none
module cbtoc_xcvr (
   input  wire logic pclk,      // Bench clock.
   input  wire logic n_a,       // Line A pulled low.
   input  wire logic n_b,       // Line B pulled low.
   input  wire logic use_b,     // Line B joins the bus.
   input  wire logic other_dom, // Another node sends dominant.
   input  wire logic slow,      // One more cycle of loop delay.
   output logic      rx         // Comparator output.
);
   // ---------------------------------------------------------------
   // Wired-AND bus
   // ---------------------------------------------------------------
   logic bus;
   logic bus_d;
   // Line B may be cut off, as in single-wire use.
   assign bus = ~(n_a | (n_b & use_b) | other_dom);
   // A long bus answers late; the bench picks either speed.
   always_ff @(posedge pclk) begin
      bus_d <= bus;
   end
   assign rx = slow ? bus_d : bus;
endmodule
`default_nettype wire

// ### testbench/test_cbtoc_top.sv
/* Self-checking bench for the CAN bit-timing and driver block.
   Assumes the transceiver model and the register header beside it. */
`timescale 1ns/10ps
`default_nettype none
`include "cbtoc_regs.svh"
module test_cbtoc_top;
   import cbtoc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx;
   logic        p_a, n_a, p_b, n_b, use_b, slow, other_dom, b;
   logic        sof, per_ok, bp_seen, seen_b, pb_q, na_q, nb_q;
   logic [7:0]  paddr, last_bsc, odc_q;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] per_n, hi_n, fl_n, bt, q;
   logic [64:0] e;
   logic [64:0] exp_q[$];
   logic        bit_q[$];
   cbtoc_mode_e mode, mode_q;
   int          failures, checks_done;

   cbtoc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .can_rx(rx), .p_tx_a(p_a), .n_tx_a(n_a), .p_tx_b(p_b), .n_tx_b(n_b));
   cbtoc_xcvr XCVR (.pclk(pclk), .n_a(n_a), .n_b(n_b), .use_b(use_b),
      .other_dom(other_dom), .slow(slow), .rx(rx));

   // ---------------------------------------------------------------
   // Checking and bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim();
      if (failures == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // The request holds until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= {idx, 2'h0};
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      rdat = prdata;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic rd(input logic [5:0] idx, input logic [7:0] v, m, input logic er);
      exp_q.push_back({er, 24'h0, m, 24'h0, v});
      apb(1'h0, idx, 8'h00);
   endtask

   // Configure under reset request, send one frame, await its end.
   task automatic run(input logic [7:0] odc, b0, bsc, input logic [10:0] id, input logic lose);
      mode  <= CBTOC_UNUSED;
      use_b <= (odc[1:0] == 2'h0);
      slow  <= id[0];
      apb(1'h1, `CB_IDX_CTRL, 8'h01);
      rd(`CB_IDX_BSC, last_bsc, 8'hFF, 1'h0);
      apb(1'h1, `CB_IDX_BT0, b0);
      apb(1'h1, `CB_IDX_BSC, bsc);
      apb(1'h1, `CB_IDX_ODC, odc);
      apb(1'h1, `CB_IDX_TIH, id[10:3]);
      apb(1'h1, `CB_IDX_TFC, {id[2:0], 5'h00});
      rd(`CB_IDX_TIH, id[10:3], 8'hFF, 1'h0);
      apb(1'h1, `CB_IDX_CTRL, 8'h00);
      apb(1'h1, `CB_IDX_BSC, ~bsc);
      rd(`CB_IDX_BSC, 8'h00, 8'hFF, 1'h0);
      bt = 16'((bsc[3:0] + bsc[6:4] + 3) * (b0[5:0] + 1));
      q = 16'(b0[5:0] + 1);
      odc_q = odc;
      bit_q.delete();
      if (!lose && odc[1:0] == 2'h3) begin
         bit_q.push_back(1'h0);
         for (int i = 10; i >= 0; i--) bit_q.push_back(id[i]);
      end
      apb(1'h1, `CB_IDX_CTRL, 8'h02);
      mode <= cbtoc_mode_e'(odc[1:0]);
      if (lose) begin
         while (sof !== 1'h1) @(posedge pclk);
         other_dom <= 1'h1;
      end
      do apb(1'h0, `CB_IDX_STAT, 8'h00); while (rdat[2:1] === 2'h0);
      other_dom <= 1'h0;
      rd(`CB_IDX_STAT, {5'h0, lose, ~lose, 1'h0}, 8'h06, 1'h0);
      chk(33'(bit_q.size()), 33'h0);
      if (odc[1:0] == 2'h0) chk(33'(seen_b), 33'h1);
      last_bsc = bsc;
   endtask

   // ---------------------------------------------------------------
   // Monitors
   // ---------------------------------------------------------------
   // Reads are judged as they complete, oldest expectation first.
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'h1 && !pwrite && exp_q.size() != 0) begin
         e = exp_q.pop_front();
         chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
      end
   end

   // Early falls of the bit clock are skipped: a hard sync on our own edge may
   // repeat the sync quantum, and that must not count as a second bit.
   always @(posedge pclk) begin
      pb_q   <= p_b;
      na_q   <= n_a;
      nb_q   <= n_b;
      mode_q <= mode;
      hi_n   <= p_b ? hi_n + 16'h1 : 16'h0;
      per_n  <= (p_b && !pb_q) ? 16'h1 : per_n + 16'h1;
      fl_n   <= fl_n + 16'h1;
      if (mode != mode_q) begin
         sof     <= 1'h0;
         per_ok  <= 1'h0;
         bp_seen <= 1'h0;
         seen_b  <= 1'h0;
      end else if (mode == CBTOC_NORMAL2) begin
         if (p_b && !pb_q) begin
            if (per_ok && !sof) chk(33'(per_n), 33'(bt));
            per_ok <= 1'h1;
         end
         if (!p_b && pb_q && !sof && !n_a) chk(33'(hi_n), 33'(q));
         if (!p_b && pb_q && (sof ? fl_n >= bt - q : n_a)) begin
            sof  <= 1'h1;
            fl_n <= 16'h1;
            if (bit_q.size() != 0) begin
               b = bit_q.pop_front();
               chk({31'h0, p_a, n_a}, {31'h0, b, ~b});
            end
         end
      end else if (mode == CBTOC_NORMAL1) begin
         chk({31'h0, p_a, n_a}, {31'h0, ~n_a, n_a});
         chk({31'h0, p_b, n_b}, {31'h0, odc_q[7] & (p_a != odc_q[5]),
             odc_q[6] & (p_a == odc_q[5])});
      end else if (mode == CBTOC_BIPHASE) begin
         chk({31'h0, p_a | p_b, n_a & n_b}, 33'h0);
         if ((n_a && !na_q) || (n_b && !nb_q)) begin
            if (!bp_seen) chk({31'h0, n_a, n_b}, 33'h2);
            bp_seen <= 1'h1;
            seen_b  <= seen_b | n_b;
         end
      end
   end

   // ---------------------------------------------------------------
   // Clock, sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end

   // Each pass sends one frame; the table picks mode, timing and fault.
   initial begin
      logic [10:0] id;
      {presetn, psel, penable, pwrite, use_b, slow, other_dom, sof, per_ok} = 9'h0;
      {paddr, pwdata, last_bsc, odc_q} = 56'h0;
      mode = CBTOC_UNUSED;
      failures = 0;
      checks_done = 0;
      void'($urandom(49486));
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      rd(`CB_IDX_ODC, 8'h00, 8'hFF, 1'h0);
      rd(`CB_IDX_CTRL, 8'h01, 8'h01, 1'h0);
      rd(6'h3F, 8'h00, 8'h00, 1'h1);
      for (int k = 0; k < 12; k++) begin
         id = 11'($urandom);
         if (&id[10:4]) id[10] = 1'h0;
         case (k)
            0: run(8'hDB, 8'h07, 8'h11, id, 1'h0);
            1: run(8'hDB, 8'h07, 8'hA2, id, 1'h0);
            2: run(8'hDB, 8'hFF, 8'h37, id | 11'h001, 1'h1);
            11: run(8'hD8, 8'h07, 8'h11, id, 1'h0);
            default: run({3'(k - 3), 5'h1A}, 8'h07, 8'h11, id, 1'h0);
         endcase
      end
      end_sim();
   end

   // A hang counts as a mismatch and ends the run the usual way.
   initial begin
      #600000;
      failures++;
      end_sim();
   end
endmodule
`default_nettype wire

// ### verilog/cbtoc_pkg.sv
/*
 * Types shared by the CAN bit-timing and transmit-driver block.
 * Assumes nothing of its surroundings.
 */
package cbtoc_pkg;

   // Output mode selection.
   typedef enum logic [1:0] {
      CBTOC_BIPHASE = 2'b00,
      CBTOC_UNUSED  = 2'b01,
      CBTOC_NORMAL1 = 2'b10,
      CBTOC_NORMAL2 = 2'b11
   } cbtoc_mode_e;

endpackage

// ### verilog/cbtoc_regs.svh
/*
 * Register indices, field positions, reset values and counts for the CAN
 * bit-timing and transmit-driver block. The file assumes inclusion by bare
 * name from the design; it holds definitions only.
 */
//
// Function
// [R1] Triple-sample bit set takes three samples per bit, clear takes one.
// [R2] Software should use single sampling at high bit rates.
// [R3] Every bit starts with a one-quantum sync segment expecting bus edges.
// [R4] The transmitter puts the next bit out at the start of the bit.
// [R5] Sample point lies between the phase segments; third sample when tripled.
// [R6] Phase segment before sample lasts its field value plus one quantum.
// [R7] Phase segment after sample lasts its field value plus one quantum.
// [R8] Bit time is sync plus both phase segments, in prescaled quanta.
// [R9] Software keeps the after-sample segment at least 2, or 3 when tripled.
// [R10] Software keeps the before-sample segment no shorter than the after one.
// [R11] Software keeps jump width within the after segment and below the before.
// [R12] Shortest legal bit is 5 quanta single, 7 quanta triple sampled.
// [R13] Timing and driver registers are writable only during reset request.
// [R14] Mode field: 00 biphase, 01 unused, 10 normal one, 11 normal two.
// [R15] Internal bit value is 0 for dominant and 1 for recessive.
// [R16] Biphase toggles a flip-flop per dominant bit, line A first.
// [R17] Biphase turns all drivers off for every recessive bit.
// [R18] Normal one drives the same untoggled stream on both lines.
// [R19] Normal two puts the bit clock, high during sync, on line B.
// [R20] P transistor on only when enabled and bit differs from polarity.
// [R21] N transistor on only when enabled and bit equals polarity.
// [R22] The 11-bit identifier goes out most significant bit first.
// [R23] Smaller identifier wins arbitration; a lost bit stops transmission.
// [R24] Software never loads an identifier with seven top bits recessive.
// [R25] Resync changes a bit by at most jump width plus one quantum.
// [R26] Quantum divider is prescaler field plus one, 1 to 64.
// [R27] Hard sync on the frame's first falling edge, resync on later ones.
`ifndef CBTOC_REGS_SVH
`define CBTOC_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define CB_IDX_CTRL  6'h20
`define CB_IDX_STAT  6'h22
`define CB_IDX_BT0   6'h26
`define CB_IDX_BSC   6'h27
`define CB_IDX_ODC   6'h28
`define CB_IDX_TIH   6'h2A
`define CB_IDX_TFC   6'h2B

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CB_CTRL_RR    0
`define CB_CTRL_GO    1
`define CB_BSC_TRIPLE 7
`define CB_BSC_T2     6:4
`define CB_BSC_T1     3:0
`define CB_BT0_SJW    7:6
`define CB_BT0_PRESC  5:0
`define CB_ODC_P1     7
`define CB_ODC_N1     6
`define CB_ODC_POL1   5
`define CB_ODC_P0     4
`define CB_ODC_N0     3
`define CB_ODC_POL0   2
`define CB_ODC_MODE   1:0
`define CB_TFC_IDLO   7:5

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define CB_RST_BYTE   8'h00
`define CB_ONE5       5'h01
`define CB_TWO5       5'h02
`define CB_ONE3       3'h1
`define CB_ID_BITS    4'hC
`define CB_IDLE_LAST  4'hA

`endif

// ### verilog/cbtoc_top.sv
/*
 * CAN bit timing, sampling, identifier transmission with arbitration and
 * two-line driver control, reached over APB with zero wait states.
 * Assumes can_rx comes asynchronously from a transceiver and that the
 * driver transistor gates feed pads outside this block.
 */
// Local design decision: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cbtoc_regs.svh"

module cbtoc_top (
   input  wire logic        pclk,      // APB clock, 100 MHz.
   input  wire logic        presetn,   // Asynchronous reset, active low.
   input  wire logic        psel,      // APB select.
   input  wire logic        penable,   // APB access phase.
   input  wire logic        pwrite,    // APB direction.
   input  wire logic [7:0]  paddr,     // APB byte address.
   input  wire logic [31:0] pwdata,    // APB write data.
   output logic      [31:0] prdata,    // APB read data.
   output logic             pready,    // APB ready.
   output logic             pslverr,   // APB error on unmapped address.
   input  wire logic        can_rx,    // Receive comparator, 0 dominant.
   output logic             p_tx_a,    // Line A P transistor on.
   output logic             n_tx_a,    // Line A N transistor on.
   output logic             p_tx_b,    // Line B P transistor on.
   output logic             n_tx_b     // Line B N transistor on.
);
   import cbtoc_pkg::*;

   // -------------------------------------------------------------------------
   // Register bus
   // -------------------------------------------------------------------------
   logic        pready_ff, pslverr_ff;
   logic [31:0] prdata_ff;
   logic        rr_ff;
   logic [7:0]  bsc_ff, bt0_ff, odc_ff, tih_ff, tfc_ff;
   logic        pend_ff, act_ff, done_ff, lost_ff, idle_ff, rxb_ff;

   // Decode is combinational; every answer is registered one cycle later.
   wire       setup   = psel & ~penable;
   wire       acc     = psel & penable & pready_ff;
   wire [5:0] idx     = paddr[7:2];
   wire       algn    = (paddr[1:0] == 2'b00);
   wire       h_ctrl  = algn & (idx == `CB_IDX_CTRL);
   wire       h_stat  = algn & (idx == `CB_IDX_STAT);
   wire       h_bt0   = algn & (idx == `CB_IDX_BT0);
   wire       h_bsc   = algn & (idx == `CB_IDX_BSC);
   wire       h_odc   = algn & (idx == `CB_IDX_ODC);
   wire       h_tih   = algn & (idx == `CB_IDX_TIH);
   wire       h_tfc   = algn & (idx == `CB_IDX_TFC);
   wire       mapped  = h_ctrl | h_stat | h_bt0 | h_bsc | h_odc | h_tih | h_tfc;
   wire       wr      = acc & pwrite & ~pslverr_ff;
   wire       cfg_ok  = rr_ff;                       // [R13]
   wire       go_wr   = wr & h_ctrl & pwdata[`CB_CTRL_GO] & ~pwdata[`CB_CTRL_RR];
   wire [7:0] stat_rd = {3'h0, rxb_ff, idle_ff, lost_ff, done_ff, act_ff};
   wire [7:0] cfg_rd  = h_bt0 ? bt0_ff : h_bsc ? bsc_ff : odc_ff;
   wire [7:0] rd_val  = h_ctrl ? {7'h00, rr_ff} :
                        h_stat ? stat_rd :
                        h_tih  ? tih_ff :
                        h_tfc  ? tfc_ff :
                        ((h_bt0 | h_bsc | h_odc) & cfg_ok) ? cfg_rd : 8'h00;

   // Answer in the first access cycle; a blocked register reads as zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= setup;
         pslverr_ff <= setup & ~mapped;
         prdata_ff  <= (setup & ~pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
      end
   end

   // Configuration writes; the timing and driver set is locked outside reset request.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rr_ff  <= 1'b1;
         bt0_ff <= `CB_RST_BYTE;
         bsc_ff <= `CB_RST_BYTE;
         odc_ff <= `CB_RST_BYTE;
         tih_ff <= `CB_RST_BYTE;
         tfc_ff <= `CB_RST_BYTE;
      end else begin
         if (wr & h_ctrl)
            rr_ff <= pwdata[`CB_CTRL_RR];
         if (wr & h_bt0 & cfg_ok)
            bt0_ff <= pwdata[7:0];                   // [R13]
         if (wr & h_bsc & cfg_ok)
            bsc_ff <= pwdata[7:0];                   // [R13]
         if (wr & h_odc & cfg_ok)
            odc_ff <= pwdata[7:0];                   // [R13]
         if (wr & h_tih)
            tih_ff <= pwdata[7:0];
         if (wr & h_tfc)
            tfc_ff <= pwdata[7:0];
      end
   end

   // -------------------------------------------------------------------------
   // Receive input synchroniser
   // -------------------------------------------------------------------------
   logic rx1_ff, rx2_ff, rx3_ff, rx_ff, rxp_ff;

   // Three stages; the level moves on only when stages two and three agree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx1_ff <= 1'b1;
         rx2_ff <= 1'b1;
         rx3_ff <= 1'b1;
         rx_ff  <= 1'b1;
         rxp_ff <= 1'b1;
      end else begin
         rx1_ff <= can_rx;
         rx2_ff <= rx1_ff;
         rx3_ff <= rx2_ff;
         if (rx2_ff == rx3_ff)
            rx_ff <= rx3_ff;
         rxp_ff <= rx_ff;
      end
   end

   // -------------------------------------------------------------------------
   // Bit timing
   // -------------------------------------------------------------------------
   logic [5:0] presc_ff;
   logic [4:0] seg_ff;
   logic [2:0] ext_ff, shr_ff;
   logic       rsd_ff;

   wire        run      = ~rr_ff;
   wire [3:0]  t1       = bsc_ff[`CB_BSC_T1];
   wire [2:0]  t2       = bsc_ff[`CB_BSC_T2];
   wire        triple   = bsc_ff[`CB_BSC_TRIPLE];
   wire [2:0]  sjw1     = {1'b0, bt0_ff[`CB_BT0_SJW]} + `CB_ONE3;      // [R25]
   wire        tq_tick  = run & (presc_ff == bt0_ff[`CB_BT0_PRESC]);  // [R26]
   // Sync is quantum 0; phase one ends at seg1_end; the bit ends at bit_last.
   wire [4:0]  seg1_end = {1'b0, t1} + `CB_ONE5 + {2'b00, ext_ff};    // [R6]
   wire [4:0]  bit_last = seg1_end + {2'b00, t2} + `CB_ONE5
                          - {2'b00, shr_ff};                         // [R7] [R8] [R12]
   wire        bit_end  = tq_tick & (seg_ff == bit_last);
   wire        smp_pt   = tq_tick & (seg_ff == seg1_end);             // [R5]
   wire        rx_fall  = rxp_ff & ~rx_ff;
   wire        hard     = run & rx_fall & idle_ff;                    // [R27]
   wire        resync   = run & rx_fall & ~idle_ff & ~rsd_ff & (seg_ff != 5'h00);
   wire        in_ph2   = seg_ff > seg1_end;
   wire [4:0]  to_end   = bit_last - seg_ff + `CB_ONE5;
   wire        jump     = resync & in_ph2 & (to_end <= {2'b00, sjw1});
   wire [2:0]  ext_n    = (seg_ff < {2'b00, sjw1}) ? seg_ff[2:0] : sjw1;

   // Quantum and segment counters with hard sync and bounded resync.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_ff <= 6'h00;
         seg_ff   <= 5'h00;
         ext_ff   <= 3'h0;
         shr_ff   <= 3'h0;
         rsd_ff   <= 1'b0;
      end else if (!run || hard || jump) begin
         presc_ff <= 6'h00;
         seg_ff   <= 5'h00;                        // [R3] [R27]
         ext_ff   <= 3'h0;
         shr_ff   <= 3'h0;
         rsd_ff   <= jump;
      end else begin
         presc_ff <= tq_tick ? 6'h00 : presc_ff + 6'h01;
         if (bit_end) begin
            seg_ff <= 5'h00;
            ext_ff <= 3'h0;
            shr_ff <= 3'h0;
            rsd_ff <= 1'b0;
         end else if (tq_tick)
            seg_ff <= seg_ff + `CB_ONE5;
         if (resync & ~in_ph2) begin
            ext_ff <= ext_n;                       // [R25] [R27]
            rsd_ff <= 1'b1;
         end else if (resync) begin
            shr_ff <= sjw1;                        // [R25]
            rsd_ff <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Sampling and bus idle detection
   // -------------------------------------------------------------------------
   logic       sa_ff, sb_ff;
   logic [3:0] idle_cnt_ff;
   // Majority of three costs a bit of delay but rejects single spikes.
   wire        maj    = (sa_ff & sb_ff) | (sa_ff & rx_ff) | (sb_ff & rx_ff);
   wire        rx_now = triple ? maj : rx_ff;                        // [R1]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sa_ff       <= 1'b1;
         sb_ff       <= 1'b1;
         rxb_ff      <= 1'b1;
         idle_cnt_ff <= 4'h0;
         idle_ff     <= 1'b0;
      end else if (!run) begin
         idle_cnt_ff <= 4'h0;
         idle_ff     <= 1'b0;
      end else begin
         if (tq_tick & (seg_ff == seg1_end - `CB_TWO5))
            sa_ff <= rx_ff;                          // [R1]
         if (tq_tick & (seg_ff == seg1_end - `CB_ONE5))
            sb_ff <= rx_ff;                          // [R1]
         if (smp_pt) begin
            rxb_ff <= rx_now;                        // [R5]
            if (!rx_now)
               idle_cnt_ff <= 4'h0;
            else if (idle_cnt_ff != `CB_IDLE_LAST)
               idle_cnt_ff <= idle_cnt_ff + 4'h1;
         end
         if (hard | (smp_pt & ~rx_now))
            idle_ff <= 1'b0;
         else if (smp_pt & (idle_cnt_ff == `CB_IDLE_LAST))
            idle_ff <= 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Identifier transmission and arbitration
   // -------------------------------------------------------------------------
   logic [10:0] shift_ff;
   logic [3:0]  cnt_ff;
   logic        tx_ff, sel_ff;
   wire         tx_go  = act_ff & (cnt_ff != `CB_ID_BITS);
   wire         load   = ~act_ff & pend_ff & idle_ff;
   wire         nxt_tx = tx_go ? shift_ff[10] : ~load;   // [R15]
   wire         lose   = smp_pt & act_ff & tx_ff & ~rx_now;

   // A new bit leaves at the transmit point; flag sets win over clears.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ff    <= 1'b1;
         sel_ff   <= 1'b0;
         act_ff   <= 1'b0;
         pend_ff  <= 1'b0;
         done_ff  <= 1'b0;
         lost_ff  <= 1'b0;
         cnt_ff   <= 4'h0;
         shift_ff <= 11'h000;
      end else if (!run) begin
         // The toggle restarts so the first dominant bit after setup uses line A.
         tx_ff   <= 1'b1;
         sel_ff  <= 1'b0;                             // [R16]
         act_ff  <= 1'b0;
         pend_ff <= 1'b0;
      end else begin
         if (bit_end) begin
            tx_ff <= nxt_tx;                          // [R4]
            if (!nxt_tx)
               sel_ff <= ~sel_ff;                     // [R16]
         end
         if (bit_end & tx_go) begin
            shift_ff <= {shift_ff[9:0], 1'b1};        // [R22]
            cnt_ff   <= cnt_ff + 4'h1;
         end else if (bit_end & load) begin
            shift_ff <= {tih_ff, tfc_ff[`CB_TFC_IDLO]}; // [R22]
            cnt_ff   <= 4'h1;
         end
         if (lose | (bit_end & act_ff & ~tx_go))
            act_ff <= 1'b0;                           // [R23]
         else if (bit_end & load)
            act_ff <= 1'b1;
         if (go_wr)
            pend_ff <= 1'b1;
         else if (bit_end & load)
            pend_ff <= 1'b0;
         if (bit_end & act_ff & ~tx_go)
            done_ff <= 1'b1;
         else if (go_wr)
            done_ff <= 1'b0;
         if (lose)
            lost_ff <= 1'b1;                          // [R23]
         else if (go_wr)
            lost_ff <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Output drivers
   // -------------------------------------------------------------------------
   cbtoc_mode_e mode;
   logic [1:0]  drv_p_ff, drv_n_ff;
   assign mode = cbtoc_mode_e'(odc_ff[`CB_ODC_MODE]);                  // [R14]
   wire         txclk = run & (seg_ff == 5'h00);                       // [R19]
   wire         bp    = (mode == CBTOC_BIPHASE);
   // In biphase only the selected line drives, and only a dominant bit.
   wire [1:0]   en    = bp ? {~tx_ff & ~sel_ff, ~tx_ff & sel_ff} :     // [R16] [R17]
                        (mode == CBTOC_UNUSED) ? 2'b00 : 2'b11;
   wire [1:0]   td    = bp ? 2'b00 :
                        (mode == CBTOC_NORMAL2) ? {txclk, tx_ff} :     // [R19]
                        {tx_ff, tx_ff};                                // [R18]
   wire [1:0]   octp  = {odc_ff[`CB_ODC_P1], odc_ff[`CB_ODC_P0]};
   wire [1:0]   octn  = {odc_ff[`CB_ODC_N1], odc_ff[`CB_ODC_N0]};
   wire [1:0]   pol   = {odc_ff[`CB_ODC_POL1], odc_ff[`CB_ODC_POL0]};
   logic [1:0]  nxt_p, nxt_n;

   // Drivers float during reset request so a half-written setup never drives.
   for (genvar i = 0; i < 2; i++) begin : g_line
      assign nxt_p[i] = run & en[i] & octp[i] & (td[i] != pol[i]);    // [R20]
      assign nxt_n[i] = run & en[i] & octn[i] & (td[i] == pol[i]);    // [R21]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_p_ff <= 2'b00;
         drv_n_ff <= 2'b00;
      end else begin
         drv_p_ff <= nxt_p;
         drv_n_ff <= nxt_n;
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;
   assign p_tx_a  = drv_p_ff[0];
   assign n_tx_a  = drv_n_ff[0];
   assign p_tx_b  = drv_p_ff[1];
   assign n_tx_b  = drv_n_ff[1];

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_one_sample;
      run && !triple && smp_pt |=> rxb_ff == $past(rx_ff);
   endproperty
   a_one_sample: assert property (p_one_sample) else $error("single sample wrong"); // [R1]

   property p_sync_first;
      bit_end && !hard && !jump |=> seg_ff == 5'h00 && presc_ff == 6'h00;
   endproperty
   a_sync_first: assert property (p_sync_first) else $error("sync segment wrong"); // [R3]

   property p_tx_at_start;
      run && $changed(tx_ff) && $past(run) |-> $past(bit_end);
   endproperty
   a_tx_at_start: assert property (p_tx_at_start) else $error("tx moved off bit start"); // [R4]

   property p_seg_len;
      bit_end |-> seg_ff == {1'b0, t1} + {2'b00, t2} + `CB_TWO5 + {2'b00, ext_ff} - {2'b00, shr_ff};
   endproperty
   a_seg_len: assert property (p_seg_len) else $error("bit length wrong"); // [R8]

   property p_locked;
      wr && (h_odc || h_bsc) && !rr_ff |=> $stable(odc_ff) && $stable(bsc_ff);
   endproperty
   a_locked: assert property (p_locked) else $error("locked register written"); // [R13]

   property p_bp_toggle;
      bit_end && !nxt_tx |=> sel_ff != $past(sel_ff);
   endproperty
   a_bp_toggle: assert property (p_bp_toggle) else $error("biphase toggle missed"); // [R16]

   property p_bp_float;
      run && bp && tx_ff |=> drv_p_ff == 2'b00 && drv_n_ff == 2'b00;
   endproperty
   a_bp_float: assert property (p_bp_float) else $error("recessive drive in biphase"); // [R17]

   property p_p_en;
      drv_p_ff[0] |-> $past(octp[0] && run);
   endproperty
   a_p_en: assert property (p_p_en) else $error("P on while disabled"); // [R20]

   property p_jump;
      ext_ff <= sjw1 && shr_ff <= sjw1;
   endproperty
   a_jump: assert property (p_jump) else $error("resync beyond jump width"); // [R25]

   c_hard: cover property (hard);
   c_lost: cover property (lose);
   c_done: cover property (bit_end && act_ff && !tx_go);
   c_jump: cover property (jump);

endmodule
`default_nettype wire
